// [logic/sfs_flash_sequencer.sv]
// self-programming flash sequencer: control, key, address registers
// assumes core writes arrive as one-cycle strobes synchronous to ref_clk
// Function
// R1 - only page erase or two-word program
// R2 - software runs the full sequence first
// R3 - stall processor until operation completes
// R4 - start bit 15 launches, self-clears
// R5 - program writes two words, aligned address; code accepts a program only at addresses with [1:0] = 2'b10, erase at any address
// R6 - software erases page before programming
// R7 - start only after unlock sequence
// R8 - unlock is 0x55 then 0xAA back-to-back
// R9 - software puts two nops after start
// R10 - software waits for completion
// R11 - key register write-only, reads zero
// R12 - high and low form 24-bit address
// R13 - high gives upper 8, low 16
// R14 - control selects, enables, initiates operation
// R15 - any other write breaks unlock
// R16 - unlock consumed by one start
`timescale 1ns/10ps
`include "sfs_consts.svh"
module sfs_flash_sequencer #(
    parameter int TIMER_WIDTH = 16,
    parameter int ERASE_TIME_NS = `SFS_ERASE_TIME_NS,
    parameter int PROG_TIME_NS  = `SFS_PROG_TIME_NS
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // register write port from the core
    input  wire logic        regWrite,
    input  wire logic [1:0]  regSel,
    input  wire logic [15:0] regWdata,
    // register read port to the core
    input  wire logic [1:0]  regRdSel,
    output logic [15:0]      regRdata,
    // processor stall
    output logic             cpuStall,
    // flash array command
    output logic             flashErase,
    output logic             flashProgram,
    output logic [23:0]      flashAddr,
    input  wire logic        flashReady,
    // status
    output logic             opDone,
    output logic             alignError
);
    // cycle counts, least times rounded up
    localparam int ERASE_CYCLES = (ERASE_TIME_NS + `SFS_CLK_PERIOD_NS - 1) / `SFS_CLK_PERIOD_NS;
    localparam int PROG_CYCLES  = (PROG_TIME_NS + `SFS_CLK_PERIOD_NS - 1) / `SFS_CLK_PERIOD_NS;

    function automatic logic keyHit(input logic [15:0] d, input logic [7:0] k);
        keyHit = (d[7:0] == k) && (d[15:8] == 8'h00);
    endfunction : keyHit

    sfs_pkg::sfs_key_e   key_r;
    sfs_pkg::sfs_key_e   key_nxt;
    sfs_pkg::sfs_state_e state_r;
    sfs_pkg::sfs_state_e state_nxt;
    logic [7:0]  adrHigh_r;
    logic [7:0]  adrHigh_nxt;
    logic [15:0] adrLow_r;
    logic [15:0] adrLow_nxt;
    logic        opSel_r;
    logic        opSel_nxt;
    logic        enable_r;
    logic        enable_nxt;
    logic        start_r;
    logic        start_nxt;
    logic        err_r;
    logic        err_nxt;
    logic        stall_r;
    logic        stall_nxt;
    logic        erase_r;
    logic        erase_nxt;
    logic        prog_r;
    logic        prog_nxt;
    logic [23:0] addr_r;
    logic [23:0] addr_nxt;
    logic        done_r;
    logic        done_nxt;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic        timerLoad;
    logic [TIMER_WIDTH-1:0] timerValue;
    logic        timerDone;
    logic        ctlWrite;
    logic        startReq;
    logic [23:0] fullAddr;

    assign ctlWrite = regWrite && (regSel == `SFS_SEL_CTL);
    assign startReq = ctlWrite && regWdata[`SFS_CTL_START_BIT] && regWdata[`SFS_CTL_ENABLE_BIT];
    assign fullAddr = {adrHigh_r, adrLow_r}; // [R12] [R13]

    // unlock key tracking
    always_comb begin
        key_nxt = key_r;
        if (regWrite) begin
            if (regSel == `SFS_SEL_KEY && keyHit(regWdata, `SFS_KEY_FIRST)) begin
                key_nxt = sfs_pkg::SFS_KEY_GOT_FIRST; // [R8]
            end else if (regSel == `SFS_SEL_KEY && key_r == sfs_pkg::SFS_KEY_GOT_FIRST
                         && keyHit(regWdata, `SFS_KEY_SECOND)) begin
                key_nxt = sfs_pkg::SFS_KEY_ARMED; // [R8]
            end else begin
                // any other write, including the start itself, disarms [R15] [R16]
                key_nxt = sfs_pkg::SFS_KEY_IDLE;
            end
        end
    end

    // operation sequencer
    always_comb begin
        state_nxt   = state_r;
        adrHigh_nxt = adrHigh_r;
        adrLow_nxt  = adrLow_r;
        opSel_nxt   = opSel_r;
        enable_nxt  = enable_r;
        start_nxt   = start_r;
        err_nxt     = err_r;
        stall_nxt   = stall_r;
        erase_nxt   = 1'b0;
        prog_nxt    = 1'b0;
        addr_nxt    = addr_r;
        done_nxt    = 1'b0;
        timerLoad   = 1'b0;
        timerValue  = '0;
        unique case (state_r)
            sfs_pkg::SFS_IDLE: begin
                if (regWrite && regSel == `SFS_SEL_ADRH) begin
                    adrHigh_nxt = regWdata[7:0]; // [R13]
                end
                if (regWrite && regSel == `SFS_SEL_ADRL) begin
                    adrLow_nxt = regWdata; // [R13]
                end
                if (ctlWrite) begin
                    opSel_nxt  = regWdata[`SFS_CTL_OPSEL_BIT]; // [R14]
                    enable_nxt = regWdata[`SFS_CTL_ENABLE_BIT]; // [R14]
                    err_nxt    = 1'b0;
                end
                // start without a fresh unlock is dropped silently [R7] [R15]
                if (startReq && key_r == sfs_pkg::SFS_KEY_ARMED) begin
                    if (!regWdata[`SFS_CTL_OPSEL_BIT] && fullAddr[1:0] != 2'b10) begin
                        err_nxt = 1'b1; // program with address [1:0] other than 2'b10 refused [R5]
                    end else begin
                        start_nxt = 1'b1; // [R4]
                        stall_nxt = 1'b1; // [R3]
                        addr_nxt  = fullAddr;
                        state_nxt = sfs_pkg::SFS_LAUNCH;
                    end
                end
            end
            sfs_pkg::SFS_LAUNCH: begin
                // wait for the array; erase is one page, program is two words [R1]
                if (flashReady) begin
                    erase_nxt  = opSel_r;
                    prog_nxt   = !opSel_r; // [R5]
                    timerLoad  = 1'b1;
                    timerValue = opSel_r ? TIMER_WIDTH'(ERASE_CYCLES) : TIMER_WIDTH'(PROG_CYCLES);
                    state_nxt  = sfs_pkg::SFS_BUSY;
                end
            end
            sfs_pkg::SFS_BUSY: begin
                // the timer alone ends the operation; the array was ready at launch
                if (timerDone) begin
                    start_nxt = 1'b0; // [R4]
                    stall_nxt = 1'b0; // [R3]
                    done_nxt  = 1'b1;
                    state_nxt = sfs_pkg::SFS_IDLE;
                end
            end
        endcase
    end

    // read mux; key register never echoes [R11]
    always_comb begin
        unique case (regRdSel)
            `SFS_SEL_CTL:  rdata_nxt = {start_nxt, enable_nxt, err_nxt, 12'h000, opSel_nxt};
            `SFS_SEL_KEY:  rdata_nxt = 16'h0000; // [R11]
            `SFS_SEL_ADRH: rdata_nxt = {8'h00, adrHigh_nxt};
            `SFS_SEL_ADRL: rdata_nxt = adrLow_nxt;
        endcase
    end

    sfs_busy_timer #(
        .WIDTH     (TIMER_WIDTH)
    ) u_timer (
        .ref_clk   (ref_clk),
        .rst       (rst),
        .load      (timerLoad),
        .loadValue (timerValue),
        .done      (timerDone)
    );

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            key_r     <= sfs_pkg::SFS_KEY_IDLE;
            state_r   <= sfs_pkg::SFS_IDLE;
            adrHigh_r <= 8'h00;
            adrLow_r  <= 16'h0000;
            opSel_r   <= 1'b0;
            enable_r  <= 1'b0;
            start_r   <= 1'b0;
            err_r     <= 1'b0;
            stall_r   <= 1'b0;
            erase_r   <= 1'b0;
            prog_r    <= 1'b0;
            addr_r    <= 24'h000000;
            done_r    <= 1'b0;
            rdata_r   <= 16'h0000;
        end else begin
            key_r     <= key_nxt;
            state_r   <= state_nxt;
            adrHigh_r <= adrHigh_nxt;
            adrLow_r  <= adrLow_nxt;
            opSel_r   <= opSel_nxt;
            enable_r  <= enable_nxt;
            start_r   <= start_nxt;
            err_r     <= err_nxt;
            stall_r   <= stall_nxt;
            erase_r   <= erase_nxt;
            prog_r    <= prog_nxt;
            addr_r    <= addr_nxt;
            done_r    <= done_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    assign regRdata     = rdata_r;
    assign cpuStall     = stall_r;
    assign flashErase   = erase_r;
    assign flashProgram = prog_r;
    assign flashAddr    = addr_r;
    assign opDone       = done_r;
    assign alignError   = err_r;
endmodule : sfs_flash_sequencer

// [logic/sfs_consts.svh]
// constants for the self-programming flash sequencer
// assumes a 16-bit special function register write port from the core
`ifndef SFS_CONSTS_SVH
`define SFS_CONSTS_SVH
`define SFS_CTL_START_BIT   15
`define SFS_CTL_ENABLE_BIT  14
`define SFS_CTL_ERROR_BIT   13
`define SFS_CTL_OPSEL_BIT   0
`define SFS_KEY_FIRST       8'h55
`define SFS_KEY_SECOND      8'hAA
`define SFS_SEL_CTL         2'h0
`define SFS_SEL_KEY         2'h1
`define SFS_SEL_ADRH        2'h2
`define SFS_SEL_ADRL        2'h3
`define SFS_ERASE_TIME_NS   20000
`define SFS_PROG_TIME_NS    50000
`define SFS_CLK_PERIOD_NS   8
`endif

// [logic/sfs_pkg.sv]
// types for the self-programming flash sequencer
// used with sfs_consts.svh
package sfs_pkg;
    typedef enum logic [1:0] {
        SFS_KEY_IDLE,
        SFS_KEY_GOT_FIRST,
        SFS_KEY_ARMED
    } sfs_key_e;
    typedef enum logic [1:0] {
        SFS_IDLE,
        SFS_LAUNCH,
        SFS_BUSY
    } sfs_state_e;
endpackage : sfs_pkg

// [logic/sfs_busy_timer.sv]
// down-counter that times one flash operation
// assumes load is a single-cycle pulse while idle
`timescale 1ns/10ps
module sfs_busy_timer #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // control
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] loadValue,
    // status
    output logic                  done
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    logic             done_r;
    logic             done_nxt;

    always_comb begin
        count_nxt = count_r;
        done_nxt  = 1'b0;
        if (load) begin
            count_nxt = loadValue;
        end else if (count_r != '0) begin
            count_nxt = count_r - WIDTH'(1);
            done_nxt  = (count_r == WIDTH'(1));
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            count_r <= '0;
            done_r  <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_r  <= done_nxt;
        end
    end

    assign done = done_r;
endmodule : sfs_busy_timer

// [test/sfs_flash_sequencer_checker.sv]
// port checker for the flash sequencer
// assumes binding onto sfs_flash_sequencer
`timescale 1ns/10ps
`include "sfs_consts.svh"
module sfs_flash_sequencer_checker (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // core side
    input wire logic        regWrite,
    input wire logic [1:0]  regSel,
    input wire logic [15:0] regWdata,
    input wire logic [1:0]  regRdSel,
    input wire logic [15:0] regRdata,
    input wire logic        cpuStall,
    // flash side
    input wire logic        flashErase,
    input wire logic        flashProgram,
    input wire logic [23:0] flashAddr,
    input wire logic        flashReady,
    input wire logic        opDone,
    input wire logic        alignError
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // bit0 first key last, bit1 full unlock last
    logic [1:0] keyHist_r;
    logic [1:0] keyHist_nxt;
    logic       isKey;
    always_comb begin
        isKey = regWrite && regSel == `SFS_SEL_KEY;
        keyHist_nxt = regWrite ? {isKey && regWdata == 16'h00AA && keyHist_r[0], isKey && regWdata == 16'h0055}
                               : keyHist_r;
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) keyHist_r <= 2'h0;
        else keyHist_r <= keyHist_nxt;
    end
    property p_startNeedsKey; regWrite && regSel == `SFS_SEL_CTL && regWdata[15] && !keyHist_r[1] && !cpuStall
        |=> !cpuStall; endproperty
    a_startNeedsKey: assert property (p_startNeedsKey) else $error("start without unlock");
    property p_stallRise; regWrite && regSel == `SFS_SEL_CTL && regWdata[15:14] == 2'h3 && regWdata[0]
        && keyHist_r[1] && !cpuStall |=> cpuStall; endproperty
    a_stallRise: assert property (p_stallRise) else $error("erase start missed");
    property p_stallHold; cpuStall |=> cpuStall || opDone; endproperty
    a_stallHold: assert property (p_stallHold) else $error("stall dropped early");
    property p_fallDone; $fell(cpuStall) |-> opDone; endproperty
    a_fallDone: assert property (p_fallDone) else $error("stall fell without done");
    property p_donePulse; opDone |=> !opDone && !cpuStall; endproperty
    a_donePulse: assert property (p_donePulse) else $error("done too long");
    property p_cmdShape; flashErase || flashProgram |-> cpuStall && !(flashErase && flashProgram)
        ##1 !flashErase && !flashProgram; endproperty
    a_cmdShape: assert property (p_cmdShape) else $error("bad command pulse");
    property p_readyGate; flashErase || flashProgram |-> $past(flashReady); endproperty
    a_readyGate: assert property (p_readyGate) else $error("command while not ready");
    property p_keyRead; regRdSel == `SFS_SEL_KEY |=> regRdata == 16'h0000; endproperty
    a_keyRead: assert property (p_keyRead) else $error("key readable");
    property p_alignBlock; flashProgram |-> !alignError && flashAddr[1:0] == 2'b10; endproperty
    a_alignBlock: assert property (p_alignBlock) else $error("misaligned program");
endmodule : sfs_flash_sequencer_checker

bind sfs_flash_sequencer sfs_flash_sequencer_checker u_chk (.*);

// [test/sfs_flash_sequencer_tb.sv]
// self-checking bench for the flash sequencer
// assumes sfs_consts.svh on the include path
`timescale 1ns/10ps
`include "sfs_consts.svh"
module sfs_flash_sequencer_tb;
    logic        ref_clk, rst, regWrite, flashReady, cpuStall, flashErase, flashProgram, opDone, alignError;
    logic [1:0]  regSel, regRdSel;
    logic [15:0] regWdata, regRdata;
    logic [23:0] flashAddr;
    int          n_mismatch = 0;
    int          cmp_count = 0;
    // short times keep each operation to ten cycles
    sfs_flash_sequencer #(.ERASE_TIME_NS(80), .PROG_TIME_NS(80)) DUT (.*);
    // rows: control word and target address
    logic [15:0] rowCtl [4] = '{16'hC001, 16'hC000, 16'hC000, 16'hC000};
    logic [23:0] rowAdr [4] = '{24'h123400, 24'h000002, 24'h000006, 24'hABCDEE};
    task automatic chk(input string name, input logic [23:0] exp, input logic [23:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
            n_mismatch++;
        end
    endtask : chk
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : report_and_stop
    // one cycle gap after each write, so the strobe is never set twice in a step
    task automatic wr(input logic [1:0] sel, input logic [15:0] data);
        @(negedge ref_clk);
        regWrite = 1'b1;
        regSel = sel;
        regWdata = data;
        @(negedge ref_clk);
        regWrite = 1'b0;
    endtask : wr
    task automatic unlock();
        wr(`SFS_SEL_KEY, 16'h0055);
        wr(`SFS_SEL_KEY, 16'h00AA);
    endtask : unlock
    task automatic waitFor(input bit done);
        int i;
        for (i = 0; i < 100; i++) begin
            @(negedge ref_clk);
            if ((done ? opDone : flashErase | flashProgram) === 1'b1) break;
        end
        if (i == 100) begin
            $display("MISMATCH wait expected 1 seen 0");
            n_mismatch++;
            report_and_stop();
        end
    endtask : waitFor
    task automatic noStart(input string name);
        repeat (4) @(negedge ref_clk);
        chk(name, 24'h0, {23'h0, cpuStall});
        $display("test %s done", name);
    endtask : noStart
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    initial begin
        rst = 1'b1;
        regWrite = 1'b0;
        regSel = 2'h0;
        regWdata = 16'h0;
        regRdSel = 2'h0;
        flashReady = 1'b1;
        repeat (5) @(negedge ref_clk);
        rst = 1'b0;
        chk("idle", 24'h0, {19'h0, cpuStall, flashErase, flashProgram, opDone, alignError});
        for (int r = 0; r < 4; r++) begin
            wr(`SFS_SEL_ADRH, {8'h00, rowAdr[r][23:16]});
            wr(`SFS_SEL_ADRL, rowAdr[r][15:0]);
            unlock();
            flashReady = (r != 0);
            wr(`SFS_SEL_CTL, rowCtl[r]);
            // a ready array takes the command one cycle after launch, so only wait when held off
            if (r == 0) begin
                repeat (3) @(negedge ref_clk);
            end
            flashReady = 1'b1;
            waitFor(1'b0);
            chk("kind", {22'h0, rowCtl[r][0], ~rowCtl[r][0]}, {22'h0, flashErase, flashProgram});
            chk("addr", rowAdr[r], flashAddr);
            chk("stall", 24'h1, {23'h0, cpuStall});
            waitFor(1'b1);
            chk("release", 24'h0, {23'h0, cpuStall});
            $display("test row %0d done", r);
        end
        wr(`SFS_SEL_CTL, 16'hC001);
        noStart("no key");
        unlock();
        wr(`SFS_SEL_CTL, 16'hC001);
        waitFor(1'b1);
        wr(`SFS_SEL_CTL, 16'hC001);
        noStart("reuse");
        wr(`SFS_SEL_KEY, 16'h0055);
        wr(`SFS_SEL_ADRL, 16'h0004);
        wr(`SFS_SEL_KEY, 16'h00AA);
        wr(`SFS_SEL_CTL, 16'hC001);
        noStart("broken");
        unlock();
        wr(`SFS_SEL_CTL, 16'hC000);
        noStart("misaligned");
        chk("align", 24'h1, {23'h0, alignError});
        wr(`SFS_SEL_CTL, 16'h4000);
        chk("align clear", 24'h0, {23'h0, alignError});
        unlock();
        regRdSel = `SFS_SEL_KEY;
        repeat (2) @(negedge ref_clk);
        chk("key read", 24'h0, {8'h0, regRdata});
        regRdSel = `SFS_SEL_ADRL;
        repeat (2) @(negedge ref_clk);
        chk("low read", 24'h000004, {8'h0, regRdata});
        regRdSel = `SFS_SEL_ADRH;
        repeat (2) @(negedge ref_clk);
        chk("high read", 24'h0000AB, {8'h0, regRdata});
        report_and_stop();
    end
endmodule : sfs_flash_sequencer_tb
